// ==== dbc_config_decode.sv ====
// Configuration decode for the drive bay bridge: holds the two configuration bytes
// loaded from serial memory and the output level byte, and decodes them onto pins.
// Assumes the serial memory loader writes these registers over the plain port and then
// pulses the load-done bit; pin inputs arrive asynchronously and are synchronised here.
//
// Added by the designer: the address-and-strobe port.

// Functional notes
// R1: Button mode routes three pins to status
// R2: Button mode stays clear on small package; the code does not clear it when the small pinout is selected
// R3: Boot scan bit requests storage bus probe
// R4: Boot scan matches fixed drive presence
// R5: Pinout select chooses small or wide
// R6: Suspend float tristates storage bus pins
// R7: Unshared bus keeps suspend float clear
// R8: Reserved feature bits three, two zero
// R9: Polarity bit sets power-valid active level
// R10: Enable bit honours power-valid, removable master
// R11: Direction bits make pins input or output
// R12: Input pins reported as sampled levels
// R13: Output pins driven from level byte
// R14: Direction upper bits written as zero
// R15: Level bit zero low, one high
// R16: Bytes loaded before any feature acts; the suspend float bit gates storage_bus_oe before load
module dbc_config_decode (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Register port
    input wire dbc_pkg::dbc_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // Board pins
    input wire logic drive_power_valid_in,
    input wire logic bus_pullup_enable_pin,
    input wire logic high_power_grant_pin,
    input wire logic [5:0] gpio_in,
    output logic [5:0] gpio_out,
    output logic [5:0] gpio_oe,
    // Device state
    input wire logic suspend_active,
    input wire logic scan_done,
    output logic boot_scan_start,
    output logic wide_pinout_active,
    output logic storage_bus_oe,
    output logic drive_present,
    output logic removable_master,
    output logic [2:0] status_in_endpoint,
    output logic [5:0] system_interrupt_report
);
    localparam int SYNC_W = 9;

    logic [7:0] feature_reg, feature_next;
    logic [7:0] direction_reg, direction_next;
    logic [7:0] level_reg, level_next;
    logic loaded_reg, loaded_next;
    logic [7:0] rdata_reg, rdata_next;
    dbc_pkg::dbc_state_t state_reg, state_next;
    logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync3_reg;
    logic [SYNC_W-1:0] clean_reg;
    // A net, so that each filter slice below drives only its own bit.
    wire logic [SYNC_W-1:0] clean_next;
    logic [5:0] gpio_out_reg, gpio_out_next;
    logic [5:0] gpio_oe_reg, gpio_oe_next;
    logic scan_start_reg, scan_start_next;
    logic wide_reg, wide_next;
    logic bus_oe_reg, bus_oe_next;
    logic present_reg, present_next;
    logic rem_reg, rem_next;
    logic [2:0] ep_reg, ep_next;
    logic [5:0] irq_rep_reg, irq_rep_next;
    dbc_pkg::dbc_feature_t feat;
    logic pwr_valid;

    function automatic logic wr_hit(input dbc_pkg::dbc_bus_req_t r, input logic [7:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    // Three-stage synchroniser; only the second and third stages are compared.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= {drive_power_valid_in, bus_pullup_enable_pin, high_power_grant_pin, gpio_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_filter
            assign clean_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync3_reg[gi] : clean_reg[gi];
        end
    endgenerate

    // Register file. Reserved bits are masked so they always read as zero.
    always_comb begin
        feature_next = feature_reg;
        direction_next = direction_reg;
        level_next = level_reg;
        loaded_next = loaded_reg;
        if (wr_hit(bus_req, dbc_pkg::ADDR_PIN_FEATURE_CONFIG)) begin
            feature_next = bus_req.wdata & dbc_pkg::FEATURE_WRITE_MASK; // [R8]
        end
        if (wr_hit(bus_req, dbc_pkg::ADDR_GENERAL_PIN_DIRECTION)) begin
            direction_next = bus_req.wdata & dbc_pkg::GPIO_WRITE_MASK; // [R14]
        end
        if (wr_hit(bus_req, dbc_pkg::ADDR_GENERAL_PIN_LEVEL)) begin
            level_next = bus_req.wdata & dbc_pkg::GPIO_WRITE_MASK;
        end
        if (wr_hit(bus_req, dbc_pkg::ADDR_LOAD_CONTROL) && bus_req.wdata[0]) begin
            loaded_next = 1'b1; // [R16]
        end
        rdata_next = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                dbc_pkg::ADDR_PIN_FEATURE_CONFIG: rdata_next = feature_reg;
                dbc_pkg::ADDR_GENERAL_PIN_DIRECTION: rdata_next = direction_reg;
                dbc_pkg::ADDR_GENERAL_PIN_LEVEL: rdata_next = level_reg;
                dbc_pkg::ADDR_LOAD_CONTROL: rdata_next = {7'h00, loaded_reg};
                dbc_pkg::ADDR_STATUS: rdata_next = {5'h00, state_reg};
                dbc_pkg::ADDR_PIN_INPUTS: rdata_next = {2'h0, clean_reg[5:0]};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            feature_reg <= dbc_pkg::FEATURE_RESET;
            direction_reg <= dbc_pkg::DIRECTION_RESET;
            level_reg <= dbc_pkg::LEVEL_RESET;
            loaded_reg <= 1'b0;
            rdata_reg <= 8'h00;
            clean_reg <= '0;
        end else begin
            feature_reg <= feature_next;
            direction_reg <= direction_next;
            level_reg <= level_next;
            loaded_reg <= loaded_next;
            rdata_reg <= rdata_next;
            clean_reg <= clean_next;
        end
    end

    always_comb begin
        feat.button_mode = feature_reg[dbc_pkg::BIT_BUTTON_MODE];
        feat.boot_drive_scan = feature_reg[dbc_pkg::BIT_BOOT_SCAN];
        feat.wide_pinout_select = feature_reg[dbc_pkg::BIT_WIDE_PINOUT];
        feat.suspend_bus_float = feature_reg[dbc_pkg::BIT_SUSPEND_FLOAT];
        feat.pwr_polarity = feature_reg[dbc_pkg::BIT_PWR_POLARITY];
        feat.pwr_enable = feature_reg[dbc_pkg::BIT_PWR_ENABLE];
        // Polarity one means the pin is high when power is valid.
        pwr_valid = feat.pwr_polarity ? clean_reg[8] : ~clean_reg[8]; // [R9]
    end

    // Sequencer: nothing acts on the bytes until the loader marks them complete.
    always_comb begin
        state_next = state_reg;
        scan_start_next = 1'b0;
        unique case (state_reg)
            dbc_pkg::ST_WAIT_LOAD: begin
                if (loaded_reg) begin // [R16]
                    if (feat.boot_drive_scan) begin // [R3]
                        state_next = dbc_pkg::ST_SCAN;
                        scan_start_next = 1'b1;
                    end else begin
                        state_next = dbc_pkg::ST_RUN;
                    end
                end
            end
            dbc_pkg::ST_SCAN: begin
                if (scan_done) begin
                    state_next = dbc_pkg::ST_RUN;
                end
            end
            dbc_pkg::ST_RUN: begin
                state_next = dbc_pkg::ST_RUN;
            end
            default: state_next = dbc_pkg::ST_WAIT_LOAD;
        endcase
    end

    // Output decode; held in safe values until loading completes, except storage_bus_oe and the input report.
    always_comb begin
        logic act;
        act = loaded_reg;
        wide_next = act & feat.wide_pinout_select; // [R5]
        bus_oe_next = ~(suspend_active & feat.suspend_bus_float); // [R6]
        gpio_oe_next = act ? direction_reg[5:0] : 6'h00; // [R11]
        gpio_out_next = level_reg[5:0] & gpio_oe_next; // [R13] [R15]
        irq_rep_next = clean_reg[5:0] & ~gpio_oe_next; // [R12]
        ep_next = (act & feat.button_mode) ? {clean_reg[7:6], clean_reg[8]} : 3'h0; // [R1]
        present_next = act & feat.pwr_enable & pwr_valid; // [R10]
        rem_next = act & feat.pwr_enable; // [R10]
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= dbc_pkg::ST_WAIT_LOAD;
            scan_start_reg <= 1'b0;
            wide_reg <= 1'b0;
            bus_oe_reg <= 1'b1;
            gpio_oe_reg <= 6'h00;
            gpio_out_reg <= 6'h00;
            irq_rep_reg <= 6'h00;
            ep_reg <= 3'h0;
            present_reg <= 1'b0;
            rem_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            scan_start_reg <= scan_start_next;
            wide_reg <= wide_next;
            bus_oe_reg <= bus_oe_next;
            gpio_oe_reg <= gpio_oe_next;
            gpio_out_reg <= gpio_out_next;
            irq_rep_reg <= irq_rep_next;
            ep_reg <= ep_next;
            present_reg <= present_next;
            rem_reg <= rem_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign boot_scan_start = scan_start_reg;
    assign wide_pinout_active = wide_reg;
    assign storage_bus_oe = bus_oe_reg;
    assign gpio_oe = gpio_oe_reg;
    assign gpio_out = gpio_out_reg;
    assign system_interrupt_report = irq_rep_reg;
    assign status_in_endpoint = ep_reg;
    assign drive_present = present_reg;
    assign removable_master = rem_reg;

    // Reserved bits never hold a one, whatever software writes.
    a_feature_reserved: assert property (@(posedge core_clk) disable iff (!arst_n) // [R8]
        feature_reg[3:2] == 2'b00)
        else $error("reserved feature bits set");

    a_dir_reserved: assert property (@(posedge core_clk) disable iff (!arst_n) // [R14]
        direction_reg[7:6] == 2'b00)
        else $error("reserved direction bits set");

    a_level_reserved: assert property (@(posedge core_clk) disable iff (!arst_n) // [R15]
        level_reg[7:6] == 2'b00)
        else $error("reserved level bits set");

    a_feature_write: assert property (@(posedge core_clk) disable iff (!arst_n) // [R8]
        bus_req.wr && bus_req.addr == dbc_pkg::ADDR_PIN_FEATURE_CONFIG
        |=> feature_reg == ($past(bus_req.wdata) & dbc_pkg::FEATURE_WRITE_MASK))
        else $error("feature write lost");

    a_dir_write: assert property (@(posedge core_clk) disable iff (!arst_n) // [R14]
        bus_req.wr && bus_req.addr == dbc_pkg::ADDR_GENERAL_PIN_DIRECTION
        |=> direction_reg == ($past(bus_req.wdata) & dbc_pkg::GPIO_WRITE_MASK))
        else $error("direction write lost");

    a_level_write: assert property (@(posedge core_clk) disable iff (!arst_n) // [R15]
        bus_req.wr && bus_req.addr == dbc_pkg::ADDR_GENERAL_PIN_LEVEL
        |=> level_reg == ($past(bus_req.wdata) & dbc_pkg::GPIO_WRITE_MASK))
        else $error("level write lost");

    // Read data is the register as it stood at the strobe's edge.
    a_feature_readback: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
        bus_req.rd && bus_req.addr == dbc_pkg::ADDR_PIN_FEATURE_CONFIG |=> bus_rdata == $past(feature_reg))
        else $error("feature readback wrong");

    a_dir_readback: assert property (@(posedge core_clk) disable iff (!arst_n) // [R11]
        bus_req.rd && bus_req.addr == dbc_pkg::ADDR_GENERAL_PIN_DIRECTION |=> bus_rdata == $past(direction_reg))
        else $error("direction readback wrong");

    // Loading, and what the block may show before it.
    a_loaded_sticky: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
        loaded_reg |=> loaded_reg)
        else $error("load flag dropped");

    a_idle_before_load: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
        !loaded_reg |=> gpio_oe == 6'h00 && !removable_master)
        else $error("acted before load");

    a_wide_before_load: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
        !loaded_reg |=> !wide_pinout_active && !drive_present && status_in_endpoint == 3'h0)
        else $error("decode before load");

    a_gpio_idle_out: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
        !loaded_reg |=> gpio_out == 6'h00)
        else $error("gpio driven before load");

    // Boot probe sequencing.
    a_scan_after_load: assert property (@(posedge core_clk) disable iff (!arst_n) // [R3]
        $rose(loaded_reg) && feat.boot_drive_scan |=> boot_scan_start)
        else $error("scan not started");

    a_scan_needs_bit: assert property (@(posedge core_clk) disable iff (!arst_n) // [R3]
        boot_scan_start |-> $past(feat.boot_drive_scan))
        else $error("scan without bit");

    a_scan_skipped: assert property (@(posedge core_clk) disable iff (!arst_n) // [R3]
        $rose(loaded_reg) && !feat.boot_drive_scan |=> !boot_scan_start && state_reg == dbc_pkg::ST_RUN)
        else $error("scan not skipped");

    a_scan_one_cycle: assert property (@(posedge core_clk) disable iff (!arst_n) // [R3]
        boot_scan_start |=> !boot_scan_start)
        else $error("scan pulse too long");

    a_scan_state: assert property (@(posedge core_clk) disable iff (!arst_n) // [R3]
        boot_scan_start |-> state_reg == dbc_pkg::ST_SCAN)
        else $error("scan pulse outside scan");

    a_scan_end: assert property (@(posedge core_clk) disable iff (!arst_n) // [R3]
        state_reg == dbc_pkg::ST_SCAN && scan_done |=> state_reg == dbc_pkg::ST_RUN)
        else $error("scan did not end");

    // Pin decode.
    a_wide_follow: assert property (@(posedge core_clk) disable iff (!arst_n) // [R5]
        loaded_reg |=> wide_pinout_active == $past(feat.wide_pinout_select))
        else $error("pinout select wrong");

    a_suspend_float: assert property (@(posedge core_clk) disable iff (!arst_n) // [R6]
        suspend_active && feat.suspend_bus_float |=> !storage_bus_oe)
        else $error("bus not floated");

    a_suspend_drive: assert property (@(posedge core_clk) disable iff (!arst_n) // [R6]
        !feat.suspend_bus_float |=> storage_bus_oe)
        else $error("bus floated");

    a_suspend_awake: assert property (@(posedge core_clk) disable iff (!arst_n) // [R6]
        !suspend_active |=> storage_bus_oe)
        else $error("bus floated while awake");

    a_gpio_level: assert property (@(posedge core_clk) disable iff (!arst_n) // [R13]
        loaded_reg |=> gpio_out == ($past(level_reg[5:0]) & gpio_oe))
        else $error("gpio level wrong");

    a_gpio_dir: assert property (@(posedge core_clk) disable iff (!arst_n) // [R11]
        loaded_reg |=> gpio_oe == $past(direction_reg[5:0]))
        else $error("gpio direction wrong");

    a_input_report: assert property (@(posedge core_clk) disable iff (!arst_n) // [R12]
        system_interrupt_report == ($past(clean_reg[5:0]) & ~gpio_oe))
        else $error("input report wrong");

    a_power_polarity: assert property (@(posedge core_clk) disable iff (!arst_n) // [R9]
        loaded_reg && feat.pwr_enable |=> drive_present == ($past(feat.pwr_polarity) == $past(clean_reg[8])))
        else $error("power polarity wrong");

    a_removable_enable: assert property (@(posedge core_clk) disable iff (!arst_n) // [R10]
        loaded_reg |=> removable_master == $past(feat.pwr_enable))
        else $error("removable master wrong");

    a_present_off: assert property (@(posedge core_clk) disable iff (!arst_n) // [R10]
        !feat.pwr_enable |=> !drive_present && !removable_master)
        else $error("power valid used while disabled");

    a_button_route: assert property (@(posedge core_clk) disable iff (!arst_n) // [R1]
        loaded_reg && feat.button_mode |=> status_in_endpoint == $past({clean_reg[7:6], clean_reg[8]}))
        else $error("button routing wrong");

    a_buttons_off: assert property (@(posedge core_clk) disable iff (!arst_n) // [R1]
        !feat.button_mode |=> status_in_endpoint == 3'h0)
        else $error("buttons reported while off");
endmodule

// ==== dbc_pkg.sv ====
// Package for the drive bay configuration decode block.
// Assumes a single core clock domain; offsets are register byte addresses on the plain port.
package dbc_pkg;
    localparam logic [7:0] ADDR_PIN_FEATURE_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_GENERAL_PIN_DIRECTION = 8'h09;
    localparam logic [7:0] ADDR_GENERAL_PIN_LEVEL = 8'h0a;
    localparam logic [7:0] ADDR_LOAD_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h11;
    localparam logic [7:0] ADDR_PIN_INPUTS = 8'h12;
    localparam int BIT_BUTTON_MODE = 7;
    localparam int BIT_BOOT_SCAN = 6;
    localparam int BIT_WIDE_PINOUT = 5;
    localparam int BIT_SUSPEND_FLOAT = 4;
    localparam int BIT_PWR_POLARITY = 1;
    localparam int BIT_PWR_ENABLE = 0;
    localparam logic [7:0] FEATURE_WRITE_MASK = 8'hf3;
    localparam logic [7:0] GPIO_WRITE_MASK = 8'h3f;
    localparam logic [7:0] FEATURE_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam int GPIO_COUNT = 6;

    typedef struct packed {
        logic button_mode;
        logic boot_drive_scan;
        logic wide_pinout_select;
        logic suspend_bus_float;
        logic pwr_polarity;
        logic pwr_enable;
    } dbc_feature_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dbc_bus_req_t;

    typedef enum logic [2:0] {
        ST_WAIT_LOAD = 3'b001,
        ST_SCAN = 3'b010,
        ST_RUN = 3'b100
    } dbc_state_t;
endpackage

// ==== dbc_board_model.sv ====
// Board and drive side model for the configuration decode block.
// Assumes one core clock; the bench supplies the external pin levels.
module dbc_board_model #(
    parameter int SCAN_CYCLES = 4
) (
    // Clock
    input wire logic core_clk,
    // Drive bus probe
    input wire logic boot_scan_start,
    output logic scan_done,
    // General-purpose pins
    input wire logic [5:0] gpio_out,
    input wire logic [5:0] gpio_oe,
    input wire logic [5:0] ext_level,
    output logic [5:0] gpio_in
);
    int cnt = 0;

    // The drive answers the probe late, so the block must wait for it.
    always @(posedge core_clk) begin
        if (boot_scan_start) begin
            cnt <= SCAN_CYCLES;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign scan_done = (cnt == 1);

    // Where the block drives a pin the wire shows its level, else the board's.
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule

// ==== testbench.sv ====
// Self-checking bench for the configuration decode block.
// Assumes the board model stands on the pin side and the bench is the bus master.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    dbc_pkg::dbc_bus_req_t bus_req = '0;
    logic [7:0] bus_rdata, rd_val;
    logic pwr_pin = 1'b0, pu_pin = 1'b0, hpg_pin = 1'b0, suspend = 1'b0;
    logic [5:0] ext_level = 6'h2a, gpio_in, gpio_out, gpio_oe, sysrep;
    logic scan_done, scan_start, wide, bus_oe, present, rem_master;
    logic [2:0] status;
    int n_mismatch = 0, n_tests = 0;

    always #5 core_clk = ~core_clk;

    dbc_config_decode dut_u (.core_clk(core_clk), .arst_n(arst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .drive_power_valid_in(pwr_pin), .bus_pullup_enable_pin(pu_pin),
        .high_power_grant_pin(hpg_pin), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .suspend_active(suspend), .scan_done(scan_done), .boot_scan_start(scan_start),
        .wide_pinout_active(wide), .storage_bus_oe(bus_oe), .drive_present(present),
        .removable_master(rem_master), .status_in_endpoint(status), .system_interrupt_report(sysrep));

    dbc_board_model board_u (.core_clk(core_clk), .boot_scan_start(scan_start), .scan_done(scan_done),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_level(ext_level), .gpio_in(gpio_in));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 rd_val = bus_rdata;
        check(what, rd_val, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset;
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
    endtask

    task automatic t_noscan;
        #1 check("bus_oe", 8'(bus_oe), 8'h01);
        check("gpio_oe", 8'(gpio_oe), 8'h00);
        rchk("feature reset", 8'h08, 8'h00);
        // Only the wide pinout bit here, so the probe stays off.
        wr(8'h08, 8'h20);
        settle(2);
        check("wide before load", 8'(wide), 8'h00);
        wr(8'h10, 8'h01);
        repeat (3) begin
            settle(1);
            check("no scan pulse", 8'(scan_start), 8'h00);
        end
        check("wide", 8'(wide), 8'h01);
        check("removable off", 8'(rem_master), 8'h00);
        rchk("state run", 8'h11, 8'h04);
        $display("test noscan done");
    endtask

    task automatic t_scan_decode;
        @(posedge core_clk);
        pu_pin <= 1'b1;
        pwr_pin <= 1'b1;
        // Every feature bit set, reserved bits three and two included.
        wr(8'h08, 8'hff);
        rchk("feature mask", 8'h08, 8'hf3);
        wr(8'h10, 8'h01);
        settle(1);
        check("scan start", 8'(scan_start), 8'h01);
        settle(1);
        check("scan start end", 8'(scan_start), 8'h00);
        rchk("state scan", 8'h11, 8'h02);
        settle(8);
        rchk("state run", 8'h11, 8'h04);
        check("wide", 8'(wide), 8'h01);
        check("removable", 8'(rem_master), 8'h01);
        check("buttons", 8'(status), 8'h05);
        check("present high", 8'(present), 8'h01);
        check("bus driven", 8'(bus_oe), 8'h01);
        @(posedge core_clk);
        suspend <= 1'b1;
        settle(3);
        check("bus float", 8'(bus_oe), 8'h00);
        // Float cleared for an unshared bus, button mode and high polarity off.
        wr(8'h08, 8'h61);
        settle(8);
        check("bus held", 8'(bus_oe), 8'h01);
        check("present low pol", 8'(present), 8'h00);
        check("buttons off", 8'(status), 8'h00);
        @(posedge core_clk);
        suspend <= 1'b0;
        $display("test scan_decode done");
    endtask

    task automatic t_gpio;
        wr(8'h09, 8'hff);
        rchk("dir mask", 8'h09, 8'h3f);
        wr(8'h09, 8'h0f);
        wr(8'h0a, 8'hc5);
        rchk("level mask", 8'h0a, 8'h05);
        // Small pinout, power-valid support off.
        wr(8'h08, 8'h40);
        settle(8);
        check("wide off", 8'(wide), 8'h00);
        check("removable cleared", 8'(rem_master), 8'h00);
        check("present disabled", 8'(present), 8'h00);
        check("gpio oe", 8'(gpio_oe), 8'h0f);
        check("gpio out", 8'(gpio_out), 8'h05);
        check("gpio report", 8'(sysrep), 8'h20);
        rchk("unmapped", 8'h20, 8'h00);
        $display("test gpio done");
    endtask

    task automatic print_verdict;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #20us;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        do_reset();
        t_noscan();
        do_reset();
        t_scan_decode();
        t_gpio();
        print_verdict();
    end
endmodule
